// [hw/slrx_link.sv]
// slrx_link: link receive tail (hold .. good/bad end) and partial power request
// assumes phy gives one decoded dword per rx_valid, synchronous to mclk
`timescale 1ns/1ps
module slrx_link
  import slrx_pkg::*;
#(
  parameter int  DW      = slrx_pkg::SLRX_DW,
  parameter int  BUF_DEP = slrx_pkg::SLRX_BUF_DEP,
  parameter bit  IS_HOST = slrx_pkg::SLRX_IS_HOST
) (
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // physical layer
  input  wire logic           phy_rdy,
  input  wire logic           rx_valid,
  input  wire slrx_pkg::slrx_prim_t rx_prim,
  input  wire logic [DW-1:0]  rx_data,
  output slrx_pkg::slrx_tx_t  tx_prim_q,
  output logic                phy_partial_q,
  // transport layer requests and status
  input  wire logic           enter_hold,
  input  wire logic           enter_pm_partial,
  input  wire logic           fifo_space,
  input  wire logic           ack_ready,
  input  wire logic           use_dmat,
  input  wire logic           crc_done,
  input  wire logic           crc_bad,
  input  wire logic           fis_good,
  input  wire logic           fis_bad,
  input  wire logic           ctrl_frame_pend,
  // transport data path
  output logic [DW-1:0]       tp_data,
  output logic                tp_valid,
  input  wire logic           tp_ready,
  // transport notifications
  output logic                crc_ok_pulse_q,
  output logic                crc_err_pulse_q,
  output logic                illegal_pulse_q,
  output logic                pm_abort_pulse_q,
  output logic                not_rdy_pulse_q,
  output logic [3:0]          state_q
);
  import slrx_pkg::*;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HOLD,
    ST_RX_DATA,
    ST_RX_ACK_PAUSE,
    ST_RX_FRAME_END_CHECK,
    ST_RX_CRC_OK_WAIT,
    ST_RX_ACCEPT,
    ST_RX_REJECT,
    ST_PARTIAL_POWER_REQUEST,
    ST_PHY_POWERDOWN_CHECK,
    ST_RX_WAIT_BUFFER,
    ST_LINK_LOST_ERROR
  } slrx_st_e;

  slrx_st_e st_q;
  slrx_st_e st_d;
  logic     crc_ok_sent_q;

  wire is_sync  = rx_prim == SLRX_RX_SYNC;
  wire is_eof   = rx_prim == SLRX_RX_EOF;
  wire is_hold  = rx_prim == SLRX_RX_HOLD;
  wire is_pmreq = (rx_prim == SLRX_RX_PMREQ_P) || (rx_prim == SLRX_RX_PMREQ_S);
  wire in_rx    = (st_q == ST_HOLD) || (st_q == ST_RX_ACK_PAUSE) || (st_q == ST_RX_FRAME_END_CHECK)
                  || (st_q == ST_RX_CRC_OK_WAIT) || (st_q == ST_RX_ACCEPT) || (st_q == ST_RX_REJECT)
                  || (st_q == ST_PARTIAL_POWER_REQUEST);
  wire lost     = in_rx && !phy_rdy;
  wire host_ctl = IS_HOST && ctrl_frame_pend && (st_q == ST_HOLD || st_q == ST_RX_ACK_PAUSE);

  // ----------------------------------------------------------------
  // data path buffer
  // ----------------------------------------------------------------
  wire buf_in_rdy;
  wire take_data = rx_valid && (rx_prim == SLRX_RX_DATA)
                   && (st_q == ST_HOLD || st_q == ST_RX_DATA || st_q == ST_RX_ACK_PAUSE);
  slrx_buf #(.W(DW), .DEPTH(BUF_DEP)) u_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_data   (rx_data),
    .in_valid  (take_data),
    .in_ready  (buf_in_rdy),
    .out_data  (tp_data),
    .out_valid (tp_valid),
    .out_ready (tp_ready)
  );
  wire space_ok = fifo_space && buf_in_rdy;

  // ----------------------------------------------------------------
  // next state; primitive decisions on a received dword, crc, fis, request and phy_rdy decisions on any cycle
  // ----------------------------------------------------------------
  logic f_crc_ok;
  logic f_crc_err;
  logic f_illegal;
  logic f_abort;

  always_comb begin
    st_d      = st_q;
    f_crc_ok  = 1'b0;
    f_crc_err = 1'b0;
    f_illegal = 1'b0;
    f_abort   = 1'b0;
    if (lost) begin
      st_d = ST_LINK_LOST_ERROR;
    end else if (host_ctl) begin
      st_d = ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (enter_pm_partial) st_d = ST_PARTIAL_POWER_REQUEST;
          else if (enter_hold) st_d = ST_HOLD;
        end
        ST_RX_DATA: begin
          if (rx_valid && !space_ok) st_d = ST_HOLD;
          else if (rx_valid && is_hold) st_d = ST_RX_ACK_PAUSE;
          else if (rx_valid && is_eof) st_d = ST_RX_FRAME_END_CHECK;
          else if (rx_valid && is_sync) st_d = ST_IDLE;
        end
        ST_HOLD: if (rx_valid) begin
          if (is_eof) st_d = ST_RX_FRAME_END_CHECK;
          else if (is_sync) begin
            st_d      = ST_IDLE;
            f_illegal = 1'b1;
          end else if (!space_ok) st_d = ST_HOLD;
          else if (is_hold) st_d = ST_RX_ACK_PAUSE;
          else st_d = ST_RX_DATA;
        end
        ST_RX_ACK_PAUSE: if (rx_valid) begin
          if (is_hold) st_d = ST_RX_ACK_PAUSE;
          else if (is_eof) st_d = ST_RX_FRAME_END_CHECK;
          else if (is_sync) begin
            st_d      = ST_IDLE;
            f_illegal = 1'b1;
          end else st_d = ST_RX_DATA;
        end
        ST_RX_FRAME_END_CHECK: begin
          if (crc_done && !crc_bad) begin
            st_d     = ST_RX_CRC_OK_WAIT;
            f_crc_ok = 1'b1;
          end else if (crc_done) begin
            st_d      = ST_RX_REJECT;
            f_crc_err = 1'b1;
          end
        end
        ST_RX_CRC_OK_WAIT: begin
          if (rx_valid && is_sync) begin
            st_d      = ST_IDLE;
            f_illegal = 1'b1;
          end else if (fis_bad) st_d = ST_RX_REJECT;
          else if (fis_good) st_d = ST_RX_ACCEPT;
        end
        ST_RX_ACCEPT: if (rx_valid && is_sync) st_d = ST_IDLE;
        ST_RX_REJECT: if (rx_valid && is_sync) st_d = ST_IDLE;
        ST_PARTIAL_POWER_REQUEST: if (rx_valid) begin
          case (rx_prim)
            SLRX_RX_PMACK: st_d = ST_PHY_POWERDOWN_CHECK;
            SLRX_RX_X_RDY: begin
              st_d    = ST_RX_WAIT_BUFFER;
              f_abort = 1'b1;
            end
            SLRX_RX_SYNC, SLRX_RX_R_OK: st_d = ST_PARTIAL_POWER_REQUEST;
            default: begin
              if (is_pmreq && !IS_HOST) st_d = ST_PARTIAL_POWER_REQUEST;
              else st_d = ST_IDLE;
            end
          endcase
        end
        ST_PHY_POWERDOWN_CHECK: if (!phy_rdy) st_d = ST_IDLE;
        ST_RX_WAIT_BUFFER: st_d = ST_IDLE;
        ST_LINK_LOST_ERROR: if (phy_rdy) st_d = ST_IDLE;
        default: st_d = ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmitted primitive per state, repeated every slot
  // ----------------------------------------------------------------
  slrx_tx_t tx_d;
  always_comb begin
    case (st_d)
      ST_HOLD:                  tx_d = SLRX_TX_HOLD;
      ST_RX_ACK_PAUSE:          tx_d = use_dmat ? SLRX_TX_DMAT : (ack_ready ? SLRX_TX_HOLDA : SLRX_TX_HOLD);
      ST_RX_DATA:               tx_d = SLRX_TX_R_IP;
      ST_RX_FRAME_END_CHECK:    tx_d = SLRX_TX_R_IP;
      ST_RX_CRC_OK_WAIT:        tx_d = SLRX_TX_R_IP;
      ST_RX_ACCEPT:             tx_d = SLRX_TX_R_OK;
      ST_RX_REJECT:             tx_d = SLRX_TX_R_ERR;
      ST_PARTIAL_POWER_REQUEST: tx_d = SLRX_TX_PMREQ_P;
      default:                  tx_d = SLRX_TX_SYNC;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q          <= ST_IDLE;
      tx_prim_q     <= slrx_tx_t'(SLRX_TX_RST);
      phy_partial_q <= 1'b0;
      crc_ok_sent_q <= 1'b0;
      state_q       <= 4'h0;
    end else begin
      st_q          <= st_d;
      tx_prim_q     <= tx_d;
      phy_partial_q <= (st_d == ST_PHY_POWERDOWN_CHECK);
      crc_ok_sent_q <= (st_d == ST_RX_CRC_OK_WAIT) && (f_crc_ok || crc_ok_sent_q);
      state_q       <= 4'(st_d);
    end
  end

  // ----------------------------------------------------------------
  // transport notifications
  // ----------------------------------------------------------------
  wire f_lost = lost;
  slrx_pulse u_p_ok  (.mclk(mclk), .nrst(nrst), .fire(f_crc_ok && !crc_ok_sent_q), .pulse_q(crc_ok_pulse_q));
  slrx_pulse u_p_err (.mclk(mclk), .nrst(nrst), .fire(f_crc_err), .pulse_q(crc_err_pulse_q));
  slrx_pulse u_p_ill (.mclk(mclk), .nrst(nrst), .fire(f_illegal), .pulse_q(illegal_pulse_q));
  slrx_pulse u_p_abt (.mclk(mclk), .nrst(nrst), .fire(f_abort), .pulse_q(pm_abort_pulse_q));
  slrx_pulse u_p_nr  (.mclk(mclk), .nrst(nrst), .fire(f_lost), .pulse_q(not_rdy_pulse_q));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_hold_eof_end: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_HOLD && phy_rdy && rx_valid && is_eof && !host_ctl |=> st_q == ST_RX_FRAME_END_CHECK)
    else $error("eof in hold not closed");
  a_hold_stays: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_HOLD && phy_rdy && rx_valid && !fifo_space && !is_eof && !is_sync && !host_ctl
    |=> st_q == ST_HOLD && tx_prim_q == SLRX_TX_HOLD)
    else $error("hold left early");
  // notification flops load on the same edge as the state, so both show together
  a_sync_illegal: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q == ST_HOLD || st_q == ST_RX_ACK_PAUSE) && phy_rdy && rx_valid && is_sync && !host_ctl
    |=> st_q == ST_IDLE && illegal_pulse_q)
    else $error("sync not reported");
  a_lost_notify: assert property (@(posedge mclk) disable iff (!nrst)
    lost |=> st_q == ST_LINK_LOST_ERROR && not_rdy_pulse_q)
    else $error("phy loss not handled");
  a_host_ctl_idle: assert property (@(posedge mclk) disable iff (!nrst)
    host_ctl && !lost |=> st_q == ST_IDLE && tx_prim_q == SLRX_TX_SYNC)
    else $error("control frame did not force idle");
  a_end_check_rip: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_RX_FRAME_END_CHECK |-> tx_prim_q == SLRX_TX_R_IP)
    else $error("frame end check not sending r_ip");
  a_crc_good: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_RX_FRAME_END_CHECK && phy_rdy && crc_done && !crc_bad
    |=> st_q == ST_RX_CRC_OK_WAIT && crc_ok_pulse_q ##1 !crc_ok_pulse_q)
    else $error("crc ok not single pulse");
  a_crc_bad: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_RX_FRAME_END_CHECK && phy_rdy && crc_done && crc_bad
    |=> st_q == ST_RX_REJECT && tx_prim_q == SLRX_TX_R_ERR && crc_err_pulse_q)
    else $error("crc error path wrong");
  a_accept_rok: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_RX_ACCEPT |-> tx_prim_q == SLRX_TX_R_OK)
    else $error("accept not sending r_ok");
  a_reject_rerr: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_RX_REJECT |-> tx_prim_q == SLRX_TX_R_ERR)
    else $error("reject not sending r_err");
  a_pm_ack_down: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_PARTIAL_POWER_REQUEST && phy_rdy && rx_valid && rx_prim == SLRX_RX_PMACK
    |=> st_q == ST_PHY_POWERDOWN_CHECK && phy_partial_q)
    else $error("power ack did not reach phy");
  a_pm_abort: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_PARTIAL_POWER_REQUEST && phy_rdy && rx_valid && rx_prim == SLRX_RX_X_RDY
    |=> st_q == ST_RX_WAIT_BUFFER && pm_abort_pulse_q)
    else $error("power abort missing");
  a_pm_wait: assert property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_PARTIAL_POWER_REQUEST && phy_rdy && rx_valid
    && (is_sync || rx_prim == SLRX_RX_R_OK || (is_pmreq && !IS_HOST))
    |=> st_q == ST_PARTIAL_POWER_REQUEST && tx_prim_q == SLRX_TX_PMREQ_P)
    else $error("power request dropped");
  c_hold_to_eof: cover property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_HOLD ##1 st_q == ST_RX_FRAME_END_CHECK);
  c_good_frame: cover property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_RX_CRC_OK_WAIT ##1 st_q == ST_RX_ACCEPT);
  c_pm_ack: cover property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_PARTIAL_POWER_REQUEST ##1 st_q == ST_PHY_POWERDOWN_CHECK);
  c_pm_abort: cover property (@(posedge mclk) disable iff (!nrst)
    st_q == ST_PARTIAL_POWER_REQUEST ##1 st_q == ST_RX_WAIT_BUFFER);

endmodule : slrx_link

// [hw/slrx_pkg.sv]
// slrx_pkg: shared constants for the receive-tail / partial power link block
// assumes a 32-bit dword path with primitives already decoded to a small code
package slrx_pkg;

  // ----------------------------------------------------------------
  // received dword classes (decoded by the phy side)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SLRX_RX_DATA    = 4'h0,
    SLRX_RX_HOLD    = 4'h1,
    SLRX_RX_HOLDA   = 4'h2,
    SLRX_RX_EOF     = 4'h3,
    SLRX_RX_SYNC    = 4'h4,
    SLRX_RX_WTRM    = 4'h5,
    SLRX_RX_R_OK    = 4'h6,
    SLRX_RX_X_RDY   = 4'h7,
    SLRX_RX_PMACK   = 4'h8,
    SLRX_RX_PMNACK  = 4'h9,
    SLRX_RX_PMREQ_P = 4'ha,
    SLRX_RX_PMREQ_S = 4'hb,
    SLRX_RX_OTHER   = 4'hc
  } slrx_prim_t;

  // ----------------------------------------------------------------
  // transmitted primitive codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SLRX_TX_SYNC    = 4'h0,
    SLRX_TX_HOLD    = 4'h1,
    SLRX_TX_HOLDA   = 4'h2,
    SLRX_TX_DMAT    = 4'h3,
    SLRX_TX_R_IP    = 4'h4,
    SLRX_TX_R_OK    = 4'h5,
    SLRX_TX_R_ERR   = 4'h6,
    SLRX_TX_PMREQ_P = 4'h7,
    SLRX_TX_R_RDY   = 4'h8
  } slrx_tx_t;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int         SLRX_DW       = 32;
  localparam int         SLRX_BUF_DEP  = 2;
  localparam logic [3:0] SLRX_TX_RST   = 4'h0;
  localparam logic       SLRX_IS_HOST  = 1'b0;

endpackage : slrx_pkg

// [hw/slrx_buf.sv]
// slrx_buf: two-entry valid/ready buffer for received data dwords
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module slrx_buf #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         nrst,
  // fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

endmodule : slrx_buf

// [hw/slrx_pulse.sv]
// slrx_pulse: registered one-cycle notification to the transport layer
// assumes the request is a single-cycle strobe from the state machine
`timescale 1ns/1ps
module slrx_pulse (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // strobe in, registered pulse out
  input  wire logic fire,
  output logic      pulse_q
);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) pulse_q <= 1'b0;
    else pulse_q <= fire;
  end
endmodule : slrx_pulse

// [tb/slrx_far_end.sv]
// slrx_far_end: opposite link layer as seen through the phy, one decoded dword per slot
// assumes the bench steers it at the falling edge of mclk
`timescale 1ns/1ps
module slrx_far_end
  import slrx_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // bench steering
  input  wire logic                 send_en,
  input  wire slrx_pkg::slrx_prim_t send_prim,
  input  wire logic [31:0]          send_data,
  input  wire logic [3:0]           ack_delay,
  // slot sent by the link block
  input  wire slrx_pkg::slrx_tx_t   tx_prim,
  // dword stream toward the link block
  output logic                      rx_valid,
  output slrx_pkg::slrx_prim_t      rx_prim,
  output logic [31:0]               rx_data
);
  logic [3:0]  wait_q;
  logic [31:0] last_q;
  wire         ack_now = (ack_delay != 4'h0) && (wait_q == ack_delay);
  // answers a partial request after ack_delay slots, zero means never
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 4'h0;
      last_q <= 32'h0;
    end else begin
      wait_q <= (tx_prim == SLRX_TX_PMREQ_P && !ack_now) ? wait_q + 4'h1 : 4'h0;
      last_q <= rx_data;
    end
  end
  assign rx_valid = send_en | ack_now;
  assign rx_prim  = ack_now ? SLRX_RX_PMACK : send_prim;
  // an idle line never repeats the last dword
  assign rx_data  = send_en ? send_data : ~last_q;
endmodule : slrx_far_end

// [tb/slrx_tb.sv]
// tb: self-checking bench for slrx_link, device and host builds side by side
// assumes slrx_far_end plays the opposite link; inputs move at the falling edge
`timescale 1ns/1ps
module tb;
  import slrx_pkg::*;
  logic        mclk, nrst, phy_rdy, send_en, enter_hold, enter_pm_partial, fifo_space, ack_ready, use_dmat;
  logic        crc_done, crc_bad, fis_good, fis_bad, ctrl_frame_pend, tp_ready, tp_valid, phy_partial_q, rx_valid;
  logic        crc_ok_pulse_q, crc_err_pulse_q, illegal_pulse_q, pm_abort_pulse_q, not_rdy_pulse_q;
  logic [3:0]  ack_delay, state_q, h_state;
  logic [31:0] send_data, rx_data, tp_data;
  slrx_prim_t  send_prim, rx_prim;
  slrx_tx_t    tx_prim_q, h_tx;
  int          mismatches, samples_checked, cycles;

  slrx_far_end far (.mclk, .nrst, .send_en, .send_prim, .send_data, .ack_delay, .tx_prim(tx_prim_q),
                    .rx_valid, .rx_prim, .rx_data);
  slrx_link dut (.mclk, .nrst, .phy_rdy, .rx_valid, .rx_prim, .rx_data, .tx_prim_q, .phy_partial_q,
                 .enter_hold, .enter_pm_partial, .fifo_space, .ack_ready, .use_dmat, .crc_done, .crc_bad,
                 .fis_good, .fis_bad, .ctrl_frame_pend, .tp_data, .tp_valid, .tp_ready, .crc_ok_pulse_q,
                 .crc_err_pulse_q, .illegal_pulse_q, .pm_abort_pulse_q, .not_rdy_pulse_q, .state_q);
  slrx_link #(.IS_HOST(1'b1)) dut_host (.mclk, .nrst, .phy_rdy, .rx_valid, .rx_prim, .rx_data,
                 .tx_prim_q(h_tx), .phy_partial_q(), .enter_hold, .enter_pm_partial, .fifo_space, .ack_ready,
                 .use_dmat, .crc_done, .crc_bad, .fis_good, .fis_bad, .ctrl_frame_pend, .tp_data(),
                 .tp_valid(), .tp_ready, .crc_ok_pulse_q(), .crc_err_pulse_q(), .illegal_pulse_q(),
                 .pm_abort_pulse_q(), .not_rdy_pulse_q(), .state_q(h_state));

  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // compare and drive helpers
  // ----------------------------------------------------------------
  task automatic miss(bit bad, string msg);
    samples_checked++;
    if (bad) begin
      mismatches++;
      $display("%s", msg);
    end
  endtask : miss
  task automatic chk4(string w, logic [3:0] e, logic [3:0] g);
    miss(g !== e, $sformatf("unexpected %s: expected %h, seen %h", w, e, g));
  endtask : chk4
  task automatic chk_tx(string w, slrx_tx_t e, slrx_tx_t g);
    miss(g !== e, $sformatf("unexpected %s: expected %h, seen %h", w, e, g));
  endtask : chk_tx
  task automatic chk1(string w, logic e, logic g);
    miss(g !== e, $sformatf("unexpected %s: expected %h, seen %h", w, e, g));
  endtask : chk1
  task automatic chk32(string w, logic [31:0] e, logic [31:0] g);
    miss(g !== e, $sformatf("unexpected %s: expected %h, seen %h", w, e, g));
  endtask : chk32
  task automatic idle(int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  // one dword slot; valid drops on the sampling edge so back-to-back calls never clash
  task automatic dword(slrx_prim_t p, logic [31:0] d);
    send_en = 1'b1;
    send_prim = p;
    send_data = d;
    @(posedge mclk);
    send_en <= 1'b0;
    @(negedge mclk);
  endtask : dword
  task automatic defaults;
    {enter_hold, enter_pm_partial, fifo_space, ack_ready, use_dmat, crc_done, crc_bad} = 7'h00;
    {fis_good, fis_bad, ctrl_frame_pend, tp_ready, send_en, phy_rdy, ack_delay} = 10'h010;
    send_prim = SLRX_RX_SYNC;
    send_data = 32'h0;
  endtask : defaults
  // short reset, then walk both builds into the asked state
  task automatic reach(logic [3:0] tgt);
    defaults();
    nrst = 1'b0;
    @(negedge mclk);
    nrst = 1'b1;
    enter_pm_partial = (tgt == 4'h8);
    enter_hold = (tgt != 4'h8);
    fifo_space = (tgt == 4'h3);
    @(negedge mclk);
    {enter_hold, enter_pm_partial} = 2'b00;
    if (tgt == 4'h3) dword(SLRX_RX_HOLD, 32'h0);
    if (tgt >= 4'h4 && tgt != 4'h8) dword(SLRX_RX_EOF, 32'h0);
    if (tgt >= 4'h5 && tgt != 4'h8) begin
      {crc_done, crc_bad} = {1'b1, tgt == 4'h7};
      @(negedge mclk);
      {crc_done, crc_bad} = 2'b00;
    end
    if (tgt == 4'h6) begin
      fis_good = 1'b1;
      @(negedge mclk);
      fis_good = 1'b0;
    end
    chk4("state reached", tgt, state_q);
  endtask : reach

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_good_frame;
    reach(4'h1);
    chk_tx("tx", SLRX_TX_HOLD, tx_prim_q);
    for (int i = 1; i <= 3; i++) dword(SLRX_RX_DATA, 32'ha5a5_0000 + 32'(i));
    chk4("state", 4'h1, state_q);
    tp_ready = 1'b1;
    for (int i = 1; i <= 2; i++) begin
      chk1("tp_valid", 1'b1, tp_valid);
      chk32("tp_data", 32'ha5a5_0000 + 32'(i), tp_data);
      @(negedge mclk);
    end
    chk1("tp_valid", 1'b0, tp_valid);
    dword(SLRX_RX_EOF, 32'h0);
    chk4("state", 4'h4, state_q);
    idle(2);
    chk_tx("tx", SLRX_TX_R_IP, tx_prim_q);
    crc_done = 1'b1;
    @(negedge mclk);
    crc_done = 1'b0;
    chk4("state", 4'h5, state_q);
    chk1("crc_ok", 1'b1, crc_ok_pulse_q);
    idle(1);
    chk1("crc_ok", 1'b0, crc_ok_pulse_q);
    chk_tx("tx", SLRX_TX_R_IP, tx_prim_q);
    fis_good = 1'b1;
    @(negedge mclk);
    fis_good = 1'b0;
    dword(SLRX_RX_DATA, 32'h0);
    chk4("state", 4'h6, state_q);
    chk_tx("tx", SLRX_TX_R_OK, tx_prim_q);
    dword(SLRX_RX_SYNC, 32'h0);
    chk4("state", 4'h0, state_q);
    $display("test good_frame finished");
  endtask : t_good_frame
  task automatic t_reject;
    reach(4'h7);
    chk_tx("tx", SLRX_TX_R_ERR, tx_prim_q);
    chk1("crc_err", 1'b1, crc_err_pulse_q);
    idle(1);
    chk1("crc_err", 1'b0, crc_err_pulse_q);
    dword(SLRX_RX_DATA, 32'h0);
    chk4("state", 4'h7, state_q);
    dword(SLRX_RX_SYNC, 32'h0);
    chk4("state", 4'h0, state_q);
    reach(4'h5);
    {fis_good, fis_bad} = 2'b11;
    @(negedge mclk);
    chk4("state", 4'h7, state_q);
    $display("test reject finished");
  endtask : t_reject
  task automatic t_ack_pause;
    reach(4'h3);
    chk_tx("tx", SLRX_TX_HOLD, tx_prim_q);
    ack_ready = 1'b1;
    dword(SLRX_RX_HOLD, 32'h0);
    chk4("state", 4'h3, state_q);
    chk_tx("tx", SLRX_TX_HOLDA, tx_prim_q);
    use_dmat = 1'b1;
    idle(1);
    chk_tx("tx", SLRX_TX_DMAT, tx_prim_q);
    dword(SLRX_RX_DATA, 32'h0);
    chk4("state", 4'h2, state_q);
    reach(4'h3);
    dword(SLRX_RX_EOF, 32'h0);
    chk4("state", 4'h4, state_q);
    $display("test ack_pause finished");
  endtask : t_ack_pause
  task automatic t_sync_and_ctl;
    logic [3:0] tg [3] = '{4'h1, 4'h3, 4'h5};
    foreach (tg[k]) begin
      reach(tg[k]);
      idle(2);
      dword(SLRX_RX_SYNC, 32'h0);
      chk4("state", 4'h0, state_q);
      chk1("illegal", 1'b1, illegal_pulse_q);
      idle(1);
      chk1("illegal", 1'b0, illegal_pulse_q);
      if (k == 2) continue;
      reach(tg[k]);
      ctrl_frame_pend = 1'b1;
      @(negedge mclk);
      chk4("host state", 4'h0, h_state);
      chk_tx("host tx", SLRX_TX_SYNC, h_tx);
      chk4("state", tg[k], state_q);
    end
    $display("test sync_and_ctl finished");
  endtask : t_sync_and_ctl
  task automatic t_phy_loss;
    logic [3:0] tg [7] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    foreach (tg[k]) begin
      reach(tg[k]);
      phy_rdy = 1'b0;
      @(negedge mclk);
      chk4("state", 4'hb, state_q);
      chk1("not_rdy", 1'b1, not_rdy_pulse_q);
      idle(1);
      chk1("not_rdy", 1'b0, not_rdy_pulse_q);
    end
    $display("test phy_loss finished");
  endtask : t_phy_loss
  task automatic t_partial;
    reach(4'h8);
    chk_tx("tx", SLRX_TX_PMREQ_P, tx_prim_q);
    dword(SLRX_RX_SYNC, 32'h0);
    dword(SLRX_RX_R_OK, 32'h0);
    chk4("host state", 4'h8, h_state);
    chk_tx("tx", SLRX_TX_PMREQ_P, tx_prim_q);
    dword(SLRX_RX_PMREQ_S, 32'h0);
    chk4("host state", 4'h0, h_state);
    dword(SLRX_RX_PMREQ_P, 32'h0);
    chk4("state", 4'h8, state_q);
    reach(4'h8);
    dword(SLRX_RX_PMNACK, 32'h0);
    chk4("host state", 4'h0, h_state);
    reach(4'h8);
    dword(SLRX_RX_X_RDY, 32'h0);
    chk4("state", 4'ha, state_q);
    chk1("pm_abort", 1'b1, pm_abort_pulse_q);
    idle(1);
    chk1("pm_abort", 1'b0, pm_abort_pulse_q);
    reach(4'h8);
    ack_delay = 4'h3;
    idle(6);
    chk4("state", 4'h9, state_q);
    chk1("phy_partial", 1'b1, phy_partial_q);
    $display("test partial finished");
  endtask : t_partial
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    defaults();
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    chk4("state", 4'h0, state_q);
    chk_tx("tx", SLRX_TX_SYNC, tx_prim_q);
    chk1("tp_valid", 1'b0, tp_valid);
    $display("test reset finished");
    t_good_frame();
    t_reject();
    t_ack_pause();
    t_sync_and_ctl();
    t_phy_loss();
    t_partial();
    tally_and_finish();
  end
endmodule : tb
